// ==== rtl/pmc_pkg.sv ====
// Constants and types for the power mode and strap capture block
`default_nettype none

package pmc_pkg;

    // ******************************
    // Register offsets on the host bus
    // ******************************
    localparam logic [7:0] PMC_ADDR_PMCTL = 8'hd4;  // power_mode_control
    localparam logic [7:0] PMC_ADDR_CCR   = 8'h08;  // chip_config_reg
    localparam logic [7:0] PMC_ADDR_RXFP  = 8'h86;  // rx_frame_pointer_reg
    localparam logic [7:0] PMC_ADDR_PORT  = 8'hf4;  // port_control_reg
    localparam logic [7:0] PMC_ADDR_GRST  = 8'h26;  // global_reset_reg

    // ******************************
    // Field positions and reset values
    // ******************************
    localparam int          PMC_MODE_LSB      = 0;
    localparam int          PMC_CCR_BUS_LSB   = 6;
    localparam int          PMC_CCR_ENDIAN    = 10;
    localparam int          PMC_RXFP_ENDIAN   = 11;
    localparam int          PMC_PORT_PSAVE    = 10;
    localparam logic [15:0] PMC_REG16_RST     = 16'h0000;

    // ******************************
    // Types
    // ******************************
    typedef enum logic [1:0] {
        PMC_NORMAL  = 2'b00,
        PMC_ENERGY  = 2'b01,
        PMC_SOFT_PD = 2'b10,
        PMC_PSAVE   = 2'b11
    } pmc_mode_t;

    typedef enum logic [1:0] {
        PMC_BUS_8  = 2'b01,
        PMC_BUS_16 = 2'b10,
        PMC_BUS_32 = 2'b11
    } pmc_bus_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } pmc_req_t;

    typedef struct packed {
        logic pll_en;
        logic phy_tx_en;
        logic phy_rx_en;
        logic phy_ed_en;
        logic mac_en;
        logic host_en;
    } pmc_gate_t;

    typedef struct packed {
        logic     big_endian;
        pmc_bus_t bus_mode;
    } pmc_strap_t;

    localparam pmc_gate_t PMC_GATE_NORMAL = 6'b111011;
    localparam pmc_gate_t PMC_GATE_PSAVE  = 6'b110011;
    localparam pmc_gate_t PMC_GATE_ENERGY = 6'b000100;
    localparam pmc_gate_t PMC_GATE_OFF    = 6'b000000;
    localparam pmc_strap_t PMC_STRAP_RST  = {1'b0, PMC_BUS_8};

endpackage : pmc_pkg

`default_nettype wire

// ==== rtl/pmc_strap_cap.sv ====
// Strap pin synchroniser and one-shot capture after reset release
`default_nettype none

module pmc_strap_cap #(
    parameter bit BUS32 = 1'b0
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Strap pins
    input  wire logic        endian_strap_pin,
    input  wire logic        bus_width_strap_pin,
    input  wire logic        eeprom_enable_strap,
    // Captured values
    output var  pmc_pkg::pmc_strap_t strap_q,
    output logic             done_q
);

    logic [2:0] meta_q;
    logic [2:0] sync_q;
    pmc_pkg::pmc_bus_t bus_w;

    // ******************************
    // Synchroniser
    // ******************************
    // Free running, so the pins are settled by the time reset lifts
    always_ff @(posedge clk) begin
        meta_q <= {endian_strap_pin, bus_width_strap_pin, eeprom_enable_strap};
        sync_q <= meta_q;
    end

    // Wide variant ignores the width strap; fitted EEPROM leaves 8-bit here
    assign bus_w = BUS32 ? pmc_pkg::PMC_BUS_32 :
                   (sync_q[1] && !sync_q[0]) ? pmc_pkg::PMC_BUS_16
                                             : pmc_pkg::PMC_BUS_8;

    // One capture in the first cycle after release, then frozen
    always_ff @(posedge clk) begin
        if (rst) begin
            strap_q <= pmc_pkg::PMC_STRAP_RST;
            done_q  <= 1'b0;
        end else if (!done_q) begin
            strap_q <= {sync_q[2], bus_w};
            done_q  <= 1'b1;
        end
    end

    // ******************************
    // Checks
    // ******************************
    AST_STRAP_STABLE: assert property (@(posedge clk) disable iff (rst)
        done_q |=> $stable(strap_q) && done_q)
        else $error("strap values changed after capture");

    AST_ENDIAN_CAPTURE: assert property (@(posedge clk) disable iff (rst)
        $rose(done_q) |-> strap_q.big_endian == $past(sync_q[2]))
        else $error("endian strap not captured");

    AST_BUS_CAPTURE: assert property (@(posedge clk) disable iff (rst)
        $rose(done_q) && !BUS32 |-> strap_q.bus_mode ==
            (($past(sync_q[1]) && !$past(sync_q[0])) ? pmc_pkg::PMC_BUS_16 : pmc_pkg::PMC_BUS_8))
        else $error("bus width strap not captured");

    AST_BUS32: assert property (@(posedge clk) disable iff (rst)
        done_q && BUS32 |-> strap_q.bus_mode == pmc_pkg::PMC_BUS_32)
        else $error("wide variant did not ignore width strap");

endmodule : pmc_strap_cap

`default_nettype wire

// ==== rtl/pmc_power_ctrl.sv ====
// Power mode selector, block gating and strap configuration registers
`default_nettype none

module pmc_power_ctrl #(
    parameter bit BUS32 = 1'b0
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Host register port
    input  wire pmc_pkg::pmc_req_t host_req,
    output logic [15:0]            host_rdata_q,
    output logic                   host_rvalid_q,
    // PHY line status
    input  wire logic              autoneg_en,
    input  wire logic              cable_disconnected,
    // Strap pins
    input  wire logic              endian_strap_pin_i,
    input  wire logic              endian_pin_func,
    output logic                   endian_strap_pin_o,
    output logic                   endian_strap_pin_oe,
    input  wire logic              bus_width_strap_pin,
    input  wire logic              eeprom_enable_strap,
    // Block enables and configuration
    output var  pmc_pkg::pmc_gate_t gate_q,
    output logic                   psave_active_q,
    output logic                   big_endian_q,
    output var  pmc_pkg::pmc_bus_t bus_mode
);

    pmc_pkg::pmc_mode_t  mode_q;
    pmc_pkg::pmc_mode_t  mode_d;
    pmc_pkg::pmc_gate_t  gate_d;
    pmc_pkg::pmc_strap_t strap;
    logic                strap_done;
    logic [15:0]         rxfp_q;
    logic [15:0]         port_q;
    logic [15:0]         ccr_w;
    logic [15:0]         rdata_d;

    // ******************************
    // Strap capture
    // ******************************
    pmc_strap_cap #(
        .BUS32 (BUS32)
    ) u_strap (
        .clk                 (clk),
        .rst                 (rst),
        .endian_strap_pin    (endian_strap_pin_i),
        .bus_width_strap_pin (bus_width_strap_pin),
        .eeprom_enable_strap (eeprom_enable_strap),
        .strap_q             (strap),
        .done_q              (strap_done)
    );

    // Pin stays an input until the capture is done
    assign endian_strap_pin_oe = strap_done;
    assign endian_strap_pin_o  = endian_pin_func;
    assign bus_mode            = strap.bus_mode;

    // ******************************
    // Address decode
    // ******************************
    // Only the global reset read reaches a sleeping host interface
    wire host_ok  = (mode_q == pmc_pkg::PMC_NORMAL) || (mode_q == pmc_pkg::PMC_PSAVE);
    wire sleeping = (mode_q == pmc_pkg::PMC_SOFT_PD) || (mode_q == pmc_pkg::PMC_ENERGY);
    wire wr_pm    = host_req.wr && host_ok && host_req.addr == pmc_pkg::PMC_ADDR_PMCTL;
    wire wr_rxfp  = host_req.wr && host_ok && host_req.addr == pmc_pkg::PMC_ADDR_RXFP;
    wire wr_port  = host_req.wr && host_ok && host_req.addr == pmc_pkg::PMC_ADDR_PORT;
    wire wake     = host_req.rd && sleeping && host_req.addr == pmc_pkg::PMC_ADDR_GRST;
    wire psave_on = (mode_q == pmc_pkg::PMC_PSAVE) && autoneg_en && cable_disconnected
                    && port_q[pmc_pkg::PMC_PORT_PSAVE];

    // Wake wins over anything else in the same cycle
    assign mode_d = wake  ? pmc_pkg::PMC_NORMAL :
                    wr_pm ? pmc_pkg::pmc_mode_t'(host_req.wdata[pmc_pkg::PMC_MODE_LSB +: 2])
                          : mode_q;

    // Fields placed by their package positions; all other bits read zero
    assign ccr_w = (16'(strap.big_endian) << pmc_pkg::PMC_CCR_ENDIAN)
                 | (16'(strap.bus_mode) << pmc_pkg::PMC_CCR_BUS_LSB);

    // ******************************
    // Block gating per mode
    // ******************************
    // Power saving without its conditions behaves like normal
    always_comb begin
        case (mode_q)
            pmc_pkg::PMC_NORMAL:  gate_d = pmc_pkg::PMC_GATE_NORMAL;
            pmc_pkg::PMC_PSAVE:   gate_d = psave_on ? pmc_pkg::PMC_GATE_PSAVE
                                                    : pmc_pkg::PMC_GATE_NORMAL;
            pmc_pkg::PMC_ENERGY:  gate_d = pmc_pkg::PMC_GATE_ENERGY;
            pmc_pkg::PMC_SOFT_PD: gate_d = pmc_pkg::PMC_GATE_OFF;
            default:              gate_d = pmc_pkg::PMC_GATE_NORMAL;
        endcase
    end

    // ******************************
    // Read mux
    // ******************************
    // A disabled host interface reads back zero
    always_comb begin
        rdata_d = 16'h0000;
        if (host_ok) begin
            case (host_req.addr)
                pmc_pkg::PMC_ADDR_PMCTL: rdata_d = {14'h0000, mode_q};
                pmc_pkg::PMC_ADDR_CCR:   rdata_d = ccr_w;
                pmc_pkg::PMC_ADDR_RXFP:  rdata_d = rxfp_q;
                pmc_pkg::PMC_ADDR_PORT:  rdata_d = port_q;
                default:                 rdata_d = 16'h0000;
            endcase
        end
    end

    // ******************************
    // Registers
    // ******************************
    // Mode and gating
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q         <= pmc_pkg::PMC_NORMAL;
            gate_q         <= pmc_pkg::PMC_GATE_NORMAL;
            psave_active_q <= 1'b0;
        end else begin
            mode_q         <= mode_d;
            gate_q         <= gate_d;
            psave_active_q <= psave_on;
        end
    end

    // Software configuration and read port
    always_ff @(posedge clk) begin
        if (rst) begin
            rxfp_q        <= pmc_pkg::PMC_REG16_RST;
            port_q        <= pmc_pkg::PMC_REG16_RST;
            host_rdata_q  <= 16'h0000;
            host_rvalid_q <= 1'b0;
        end else begin
            if (wr_rxfp) rxfp_q <= host_req.wdata;
            if (wr_port) port_q <= host_req.wdata;
            host_rdata_q  <= rdata_d;
            host_rvalid_q <= host_req.rd;
        end
    end

    // Software choice only matters while the strap reads little endian
    always_ff @(posedge clk) begin
        if (rst) begin
            big_endian_q <= 1'b0;
        end else begin
            big_endian_q <= strap.big_endian || rxfp_q[pmc_pkg::PMC_RXFP_ENDIAN];
        end
    end

    // ******************************
    // Checks
    // ******************************
    sequence s_spd_wake;
        mode_q == pmc_pkg::PMC_SOFT_PD ##0
        host_req.rd && host_req.addr == pmc_pkg::PMC_ADDR_GRST;
    endsequence

    sequence s_back_up;
        mode_q == pmc_pkg::PMC_NORMAL ##1 gate_q == pmc_pkg::PMC_GATE_NORMAL;
    endsequence

    AST_RESET_NORMAL: assert property (@(posedge clk)
        rst ##1 !rst |-> mode_q == pmc_pkg::PMC_NORMAL && gate_q == pmc_pkg::PMC_GATE_NORMAL)
        else $error("mode not normal after reset");

    AST_NORMAL_GATE: assert property (@(posedge clk) disable iff (rst)
        mode_q == pmc_pkg::PMC_NORMAL |=> gate_q == pmc_pkg::PMC_GATE_NORMAL)
        else $error("normal mode gating wrong");

    AST_PSAVE_GATE: assert property (@(posedge clk) disable iff (rst)
        mode_q == pmc_pkg::PMC_PSAVE && autoneg_en && cable_disconnected
        && port_q[pmc_pkg::PMC_PORT_PSAVE] |=> gate_q == pmc_pkg::PMC_GATE_PSAVE && psave_active_q)
        else $error("power saving gating wrong");

    AST_PSAVE_COND: assert property (@(posedge clk) disable iff (rst)
        mode_q == pmc_pkg::PMC_PSAVE && !(autoneg_en && cable_disconnected)
        |=> gate_q.phy_rx_en && !psave_active_q)
        else $error("power saving active without its conditions");

    AST_ENERGY_GATE: assert property (@(posedge clk) disable iff (rst)
        mode_q == pmc_pkg::PMC_ENERGY |=> gate_q == pmc_pkg::PMC_GATE_ENERGY)
        else $error("energy detect gating wrong");

    AST_SPD_GATE: assert property (@(posedge clk) disable iff (rst)
        mode_q == pmc_pkg::PMC_SOFT_PD && !host_req.rd |=> mode_q == pmc_pkg::PMC_SOFT_PD
        ##0 gate_q == pmc_pkg::PMC_GATE_OFF)
        else $error("soft power down left or gated wrong");

    AST_MODE_WRITE: assert property (@(posedge clk) disable iff (rst)
        mode_q == pmc_pkg::PMC_NORMAL && host_req.wr && host_req.addr == pmc_pkg::PMC_ADDR_PMCTL
        |=> mode_q == $past(host_req.wdata[1:0]))
        else $error("mode write not honoured");

    AST_WAKE: assert property (@(posedge clk) disable iff (rst)
        s_spd_wake |=> s_back_up)
        else $error("global reset read did not wake");

    AST_ENDIAN_SW: assert property (@(posedge clk) disable iff (rst)
        rxfp_q[pmc_pkg::PMC_RXFP_ENDIAN] |=> big_endian_q)
        else $error("software endian choice ignored");

    AST_PIN_TURN: assert property (@(posedge clk) disable iff (rst)
        !endian_strap_pin_oe |=> endian_strap_pin_oe ##1 endian_strap_pin_oe)
        else $error("strap pin did not turn to output");

endmodule : pmc_power_ctrl

`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the power mode selector and strap capture block
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************
    // Clock, stimulus and observed signals
    // ************************************
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    pmc_pkg::pmc_req_t  req = '0;
    logic               autoneg_en = 1'b0;
    logic               cable_disconnected = 1'b0;
    logic               endian_pin = 1'b0;
    logic               pin_func = 1'b0;
    logic               width_pin = 1'b0;
    logic               eeprom_pin = 1'b0;
    logic [15:0]        rdata;
    logic               rvalid;
    logic               pin_o;
    logic               pin_oe;
    pmc_pkg::pmc_gate_t gate_q;
    logic               psave_q;
    logic               big_q;
    pmc_pkg::pmc_bus_t  bus_mode;
    int                 errors = 0;
    int                 checks = 0;
    logic [15:0]        v;

    always #5 clk = ~clk;

    pmc_power_ctrl #(.BUS32(1'b0)) DUT (
        .clk                 (clk),
        .rst                 (rst),
        .host_req            (req),
        .host_rdata_q        (rdata),
        .host_rvalid_q       (rvalid),
        .autoneg_en          (autoneg_en),
        .cable_disconnected  (cable_disconnected),
        .endian_strap_pin_i  (endian_pin),
        .endian_pin_func     (pin_func),
        .endian_strap_pin_o  (pin_o),
        .endian_strap_pin_oe (pin_oe),
        .bus_width_strap_pin (width_pin),
        .eeprom_enable_strap (eeprom_pin),
        .gate_q              (gate_q),
        .psave_active_q      (psave_q),
        .big_endian_q        (big_q),
        .bus_mode            (bus_mode)
    );

    // ************************************
    // Shared tasks
    // ************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    // Two edges so both the mode register and the registered gates settle
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        req.wr    <= 1'b1;
        req.addr  <= a;
        req.wdata <= d;
        @(posedge clk);
        req.wr    <= 1'b0;
    endtask : wr

    // Answer stands one cycle only, so it is judged right after the taking edge
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        req.rd   <= 1'b1;
        req.addr <= a;
        @(posedge clk);
        req.rd   <= 1'b0;
        #1;
        check({15'h0, rvalid}, 16'h0001, "read answer pulse");
        d = rdata;
    endtask : rd

    task automatic gate(input pmc_pkg::pmc_gate_t exp, input string msg);
        check({10'h0, gate_q}, {10'h0, exp}, msg);
    endtask : gate

    // Straps are held steady over the whole reset so the synchroniser fills
    task automatic do_reset(input logic e, input logic w);
        @(posedge clk);
        rst        <= 1'b1;
        endian_pin <= e;
        width_pin  <= w;
        repeat (3) @(posedge clk);
        #1;
        check({15'h0, pin_oe}, 16'h0000, "strap pin released in reset");
        @(posedge clk);
        rst <= 1'b0;
        settle();
    endtask : do_reset

    // ************************************
    // Scenarios
    // ************************************
    task automatic t_reset_defaults;
        do_reset(1'b0, 1'b0);
        gate(pmc_pkg::PMC_GATE_NORMAL, "gates after reset");
        rd(pmc_pkg::PMC_ADDR_PMCTL, v);
        check(v, 16'h0000, "mode after reset");
        @(posedge clk);
        #1;
        check({15'h0, rvalid}, 16'h0000, "answer lasts one cycle");
        check({14'h0, bus_mode}, {14'h0, pmc_pkg::PMC_BUS_8}, "default width");
        check({15'h0, big_q}, 16'h0000, "default order");
        check({14'h0, pin_oe, pin_o}, 16'h0002, "pin output after reset");
        rd(8'h02, v);
        check(v, 16'h0000, "unmapped read");
        $display("test reset defaults done");
    endtask : t_reset_defaults

    task automatic t_strap_capture;
        do_reset(1'b1, 1'b1);
        rd(pmc_pkg::PMC_ADDR_CCR, v);
        check({15'h0, v[10]}, 16'h0001, "endian in config");
        check({14'h0, v[7:6]}, {14'h0, pmc_pkg::PMC_BUS_16}, "width in config");
        check({14'h0, bus_mode}, {14'h0, pmc_pkg::PMC_BUS_16}, "strap high width");
        check({15'h0, big_q}, 16'h0001, "strap high order");
        @(posedge clk);
        endian_pin <= 1'b0;
        width_pin  <= 1'b0;
        pin_func   <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        check({15'h0, pin_o}, 16'h0001, "pin output function");
        check({14'h0, bus_mode}, {14'h0, pmc_pkg::PMC_BUS_16}, "width held");
        check({15'h0, big_q}, 16'h0001, "order held");
        // A fitted EEPROM leaves the width strap out of the decision
        @(posedge clk);
        eeprom_pin <= 1'b1;
        do_reset(1'b0, 1'b1);
        check({14'h0, bus_mode}, {14'h0, pmc_pkg::PMC_BUS_8}, "fitted EEPROM width");
        rd(pmc_pkg::PMC_ADDR_CCR, v);
        check({14'h0, v[7:6]}, {14'h0, pmc_pkg::PMC_BUS_8}, "fitted EEPROM config");
        @(posedge clk);
        eeprom_pin <= 1'b0;
        $display("test strap capture done");
    endtask : t_strap_capture

    task automatic t_soft_order;
        do_reset(1'b0, 1'b0);
        wr(pmc_pkg::PMC_ADDR_RXFP, 16'h0800);
        settle();
        check({15'h0, big_q}, 16'h0001, "software big order");
        wr(pmc_pkg::PMC_ADDR_RXFP, 16'h0000);
        settle();
        check({15'h0, big_q}, 16'h0000, "software little order");
        $display("test software byte order done");
    endtask : t_soft_order

    task automatic t_low_power;
        wr(pmc_pkg::PMC_ADDR_PMCTL, 16'h0001);
        settle();
        gate(pmc_pkg::PMC_GATE_ENERGY, "energy detect gates");
        wr(pmc_pkg::PMC_ADDR_PMCTL, 16'h0002);
        settle();
        gate(pmc_pkg::PMC_GATE_ENERGY, "write refused asleep");
        rd(pmc_pkg::PMC_ADDR_GRST, v);
        settle();
        gate(pmc_pkg::PMC_GATE_NORMAL, "energy wake");
        wr(pmc_pkg::PMC_ADDR_PMCTL, 16'h0002);
        settle();
        gate(pmc_pkg::PMC_GATE_OFF, "soft power down gates");
        rd(pmc_pkg::PMC_ADDR_PMCTL, v);
        check(v, 16'h0000, "host closed asleep");
        rd(pmc_pkg::PMC_ADDR_GRST, v);
        check(v, 16'h0000, "wake read data");
        settle();
        gate(pmc_pkg::PMC_GATE_NORMAL, "soft wake");
        rd(pmc_pkg::PMC_ADDR_PMCTL, v);
        check(v, 16'h0000, "mode normal after wake");
        $display("test low power modes done");
    endtask : t_low_power

    task automatic t_power_saving;
        wr(pmc_pkg::PMC_ADDR_PORT, 16'h0400);
        wr(pmc_pkg::PMC_ADDR_PMCTL, 16'h0003);
        settle();
        gate(pmc_pkg::PMC_GATE_NORMAL, "saving without link conditions");
        check({15'h0, psave_q}, 16'h0000, "saving not active");
        rd(pmc_pkg::PMC_ADDR_PMCTL, v);
        check(v, 16'h0003, "saving code read back");
        @(posedge clk);
        autoneg_en         <= 1'b1;
        cable_disconnected <= 1'b1;
        settle();
        gate(pmc_pkg::PMC_GATE_PSAVE, "saving gates");
        check({15'h0, psave_q}, 16'h0001, "saving active");
        wr(pmc_pkg::PMC_ADDR_PORT, 16'h0000);
        settle();
        gate(pmc_pkg::PMC_GATE_NORMAL, "port bit cleared");
        check({15'h0, psave_q}, 16'h0000, "saving off with port bit");
        wr(pmc_pkg::PMC_ADDR_PMCTL, 16'h0000);
        settle();
        gate(pmc_pkg::PMC_GATE_NORMAL, "back to normal");
        $display("test power saving done");
    endtask : t_power_saving

    // ************************************
    // Main sequence and watchdog
    // ************************************
    initial begin
        t_reset_defaults();
        t_strap_capture();
        t_soft_order();
        t_low_power();
        t_power_saving();
        end_sim();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        end_sim();
    end

endmodule : tb

`default_nettype wire
